// ### hdl/lkn_map.vh
// constants for the link-on notification block
`ifndef LKN_MAP_VH
`define LKN_MAP_VH

// clock rate of core_clk in MHz (20 ns period)
`define LKN_CLK_MHZ 50
// square wave: full period and half period in clock cycles
`define LKN_WAVE_PERIOD_CYC 4'h8
`define LKN_WAVE_HALF_CYC 3'h4
// longest wake time after a power cycle, in microseconds, and as cycles (rounded down)
`define LKN_PWR_WAKE_US 167
`define LKN_PWR_WAKE_CYC (`LKN_PWR_WAKE_US * `LKN_CLK_MHZ)
// highest power class that still requests a wake after a power cycle
`define LKN_PWR_CLASS_MAX 3'h4
// cycles the synchroniser needs before captured straps are trustworthy
`define LKN_STRAP_SETTLE_CYC 2'h3
// reset values
`define LKN_STRAP_RST 6'h00
`define LKN_TIMER_RST 14'h0000
`define LKN_PHASE_RST 2'h0
`define LKN_WAVE_RST 1'b0

`endif

// ### hdl/lkn_sync.v
// two-flop synchroniser for a bundle of asynchronous levels
module lkn_sync #(
  parameter WIDTH = 1
) (
  input wire core_clk,
  input wire arst_n,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage feeds the second stage only
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // lkn_sync

// ### hdl/lkn_wake_notify.v
// link-on notification driver for the combined mode-strap / wake pin
`include "lkn_map.vh"

module lkn_wake_notify #(
  parameter PWR_WAKE_CYC = `LKN_PWR_WAKE_CYC
) (
  input wire core_clk,
  input wire arst_n,
  // strap pins and the combined pin (three-signal form)
  input wire mode_strap_zero,
  input wire mode_strap_one,
  input wire mode_strap_two,
  input wire mode_strap_three,
  input wire mode_strap_four,
  input wire mode_strap_five_wake_pin_in,
  output wire mode_strap_five_wake_pin_out,
  output wire mode_strap_five_wake_pin_oe_n,
  // link layer status
  input wire link_power_status_in,
  input wire link_active_ctrl_bit,
  // interrupt register bits (levels, same clock)
  input wire port_event_irq_bit,
  input wire config_timeout_irq_bit,
  input wire cable_power_irq_bit,
  // events from the packet and reset logic (one-cycle pulses, same clock)
  input wire link_on_pkt_rx,
  input wire bus_reset_evt,
  input wire power_cycle_evt,
  input wire [2:0] power_class,
  // captured straps and status
  output wire [5:0] strap_mode,
  output wire strap_valid,
  output wire wake_notify_out,
  output wire wake_active,
  output wire wake_by_pkt,
  output wire wake_by_pwr,
  output wire pwr_wake_expired
);

  ////////////////////////////////////////////////////////////////////////////
  // derived constants

  // the give-up timer is 14 bits wide, so PWR_WAKE_CYC must not exceed 16384
  localparam [31:0] PWR_WAKE_LAST = PWR_WAKE_CYC - 1;
  // last phase of a half period and last cycle of the strap settle count
  localparam [2:0] WAVE_LAST_PHASE = `LKN_WAVE_HALF_CYC - 3'h1;
  localparam [1:0] SETTLE_LAST = `LKN_STRAP_SETTLE_CYC - 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // synchronised pins
  // link power status comes from the controller's side and is synced like the straps

  wire [6:0] pins_async;
  wire [6:0] pins_sync;
  wire [5:0] straps_sync;
  wire lps_sync;

  assign pins_async = {link_power_status_in, mode_strap_five_wake_pin_in, mode_strap_four,
                       mode_strap_three, mode_strap_two, mode_strap_one, mode_strap_zero};

  lkn_sync #(
    .WIDTH(7)
  ) u_pin_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  assign straps_sync = pins_sync[5:0];
  assign lps_sync = pins_sync[6];

  ////////////////////////////////////////////////////////////////////////////
  // strap capture

  // the pin stays undriven until the straps are captured, so the external
  // strap resistor still sets the level while the synchroniser fills
  reg [1:0] settle_q;
  reg [1:0] settle_d;
  reg strap_valid_q;
  reg strap_valid_d;
  reg [5:0] strap_q;
  reg [5:0] strap_d;
  wire settle_done;

  // both synchroniser stages hold post-reset pin samples by now, so the
  // capture never sees a level latched while reset was still applied
  assign settle_done = (settle_q == SETTLE_LAST);

  always @* begin
    settle_d = settle_q;
    strap_valid_d = strap_valid_q;
    strap_d = strap_q;
    if (!strap_valid_q) begin
      if (settle_done) begin
        strap_d = straps_sync;
        strap_valid_d = 1'b1;
      end else begin
        settle_d = settle_q + 2'h1;
      end
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_q <= 2'h0;
      strap_valid_q <= 1'b0;
      strap_q <= `LKN_STRAP_RST;
    end else begin
      settle_q <= settle_d;
      strap_valid_q <= strap_valid_d;
      strap_q <= strap_d;
    end
  end

  assign strap_mode = strap_q;
  assign strap_valid = strap_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // controller state and wake causes

  function class_may_wake;
    input [2:0] pc;
    begin
      class_may_wake = (pc <= `LKN_PWR_CLASS_MAX);
    end
  endfunction

  // a cause only takes effect while the controller is idle and the pin is ours;
  // shared by the packet, power-cycle and activation paths
  function may_start;
    input llc_act;
    input valid;
    begin
      may_start = valid & ~llc_act;
    end
  endfunction

  wire llc_active;
  wire irq_any;

  // controller counts as active only when both indications agree
  assign llc_active = lps_sync & link_active_ctrl_bit;
  // interrupt bits are levels, so a bit still set when the controller drops
  // restarts notification with no extra memory
  assign irq_any = port_event_irq_bit | config_timeout_irq_bit | cable_power_irq_bit;

  reg pkt_q;
  reg pkt_d;
  reg pwr_q;
  reg pwr_d;
  reg [13:0] pwr_tmr_q;
  reg [13:0] pwr_tmr_d;
  reg expired_q;
  reg expired_d;
  wire pwr_tmr_done;

  assign pwr_tmr_done = (pwr_tmr_q == PWR_WAKE_LAST[13:0]);

  // packet cause: set wins over the clears; a packet seen while the controller
  // is active is dropped, not remembered
  always @* begin
    pkt_d = pkt_q;
    if (llc_active) begin
      pkt_d = 1'b0;
    end
    // a bus reset drops only the packet cause, interrupt bits keep the wave going
    if (bus_reset_evt) begin
      pkt_d = 1'b0;
    end
    if (link_on_pkt_rx && may_start(llc_active, strap_valid_q)) begin
      pkt_d = 1'b1;
    end
  end

  // an interrupt bit that is also set keeps the wave going past the give-up
  // point; only the power-cycle cause itself expires
  // power-cycle cause with its give-up timer
  always @* begin
    pwr_d = pwr_q;
    pwr_tmr_d = pwr_tmr_q;
    expired_d = 1'b0;
    if (pwr_q) begin
      if (llc_active) begin
        pwr_d = 1'b0;
        pwr_tmr_d = `LKN_TIMER_RST;
      end else if (pwr_tmr_done) begin
        pwr_d = 1'b0;
        pwr_tmr_d = `LKN_TIMER_RST;
        expired_d = 1'b1;
      end else begin
        pwr_tmr_d = pwr_tmr_q + 14'h0001;
      end
    end
    // a fresh power cycle restarts the full wake window
    if (power_cycle_evt && class_may_wake(power_class) &&
        may_start(llc_active, strap_valid_q)) begin
      pwr_d = 1'b1;
      pwr_tmr_d = `LKN_TIMER_RST;
      expired_d = 1'b0;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pkt_q <= 1'b0;
      pwr_q <= 1'b0;
      pwr_tmr_q <= `LKN_TIMER_RST;
      expired_q <= 1'b0;
    end else begin
      pkt_q <= pkt_d;
      pwr_q <= pwr_d;
      pwr_tmr_q <= pwr_tmr_d;
      expired_q <= expired_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // activation

  wire any_cause;
  wire active_now;

  // interrupt bits are not cleared by a bus reset, so they keep it going
  assign any_cause = irq_any | pkt_q | pwr_q;
  assign active_now = may_start(llc_active, strap_valid_q) & any_cause;

  ////////////////////////////////////////////////////////////////////////////
  // square wave

  reg active_q;
  reg [1:0] phase_q;
  reg [1:0] phase_d;
  reg wave_q;
  reg wave_d;
  wire half_done;

  assign half_done = (phase_q == WAVE_LAST_PHASE[1:0]);

  always @* begin
    phase_d = `LKN_PHASE_RST;
    wave_d = `LKN_WAVE_RST;
    if (active_now) begin
      if (!active_q) begin
        // a new activation always begins with a full low half
        phase_d = 2'h1;
        wave_d = `LKN_WAVE_RST;
      end else if (half_done) begin
        phase_d = `LKN_PHASE_RST;
        wave_d = ~wave_q;
      end else begin
        phase_d = phase_q + 2'h1;
        wave_d = wave_q;
      end
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_q <= 1'b0;
      phase_q <= `LKN_PHASE_RST;
      wave_q <= `LKN_WAVE_RST;
    end else begin
      active_q <= active_now;
      phase_q <= phase_d;
      wave_q <= wave_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  // while undriven, the bus holder and strap resistor set the level that the
  // straps read; the output value only matters once the enable turns on
  // wave_q is forced low whenever inactive, so the idle level is a driven 0
  assign mode_strap_five_wake_pin_out = wave_q;
  assign mode_strap_five_wake_pin_oe_n = ~strap_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // status

  assign wake_notify_out = wave_q;
  assign wake_active = active_q;
  assign wake_by_pkt = pkt_q;
  assign wake_by_pwr = pwr_q;
  assign pwr_wake_expired = expired_q;

endmodule // lkn_wake_notify

// ### sim/lkn_llc_model.sv
// link layer controller model: powers up after dly+1 high wake samples
module lkn_llc_model (
  input wire core_clk,
  input wire wake_in,
  input wire sleep,
  input wire [3:0] dly,
  output logic pwr_status,
  output logic act_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  initial pwr_status = 1'h0;
  initial act_bit = 1'h0;
  always @(posedge core_clk) begin
    if (sleep) begin
      pwr_status <= 1'h0;
      act_bit <= 1'h0;
      n <= 0;
    end else if (wake_in && !pwr_status) begin
      n <= n + 1;
      pwr_status <= n >= dly;
      act_bit <= n >= dly;
    end
  end
endmodule // lkn_llc_model

// ### sim/lkn_wake_notify_checker.sv
// checker for the wake notification pin
module lkn_chk #(
  parameter PWR_WAKE_CYC = 20
) (
  input wire core_clk,
  input wire arst_n,
  input wire mode_strap_five_wake_pin_oe_n,
  input wire link_power_status_in,
  input wire link_active_ctrl_bit,
  input wire link_on_pkt_rx,
  input wire strap_valid,
  input wire wake_notify_out,
  input wire wake_active,
  input wire wake_by_pkt,
  input wire wake_by_pwr,
  input wire pwr_wake_expired,
  input wire power_cycle_evt,
  input wire [2:0] power_class
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_q;
  logic [14:0] pwr_cnt_q;
  logic [3:0] run_q;
  // run_q + 1 is how long the level in prev_q has held; saturates so idle never wraps
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= 1'h0;
      run_q <= 4'h0;
    end else begin
      prev_q <= wake_notify_out;
      run_q <= (wake_notify_out != prev_q) ? 4'h0 : run_q + {3'h0, run_q != 4'hf};
    end
  end
  // cycles that the power-cycle cause has stood since it was last (re)started
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_cnt_q <= 15'h0000;
    end else if (wake_by_pwr && !(power_cycle_evt && power_class <= 3'h4)) begin
      pwr_cnt_q <= pwr_cnt_q + 15'h0001;
    end else begin
      pwr_cnt_q <= 15'h0000;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  rst_undriven_a: assert property (
    disable iff (1'h0) !arst_n |-> mode_strap_five_wake_pin_oe_n) else $error("pin driven");
  drive_valid_a: assert property (
    $rose(arst_n) |-> mode_strap_five_wake_pin_oe_n [*3] ##1 !mode_strap_five_wake_pin_oe_n)
    else $error("pin enable timing");
  pwr_len_a: assert property (
    pwr_cnt_q <= PWR_WAKE_CYC) else $error("power wake too long");
  pwr_expire_a: assert property (
    pwr_wake_expired |-> pwr_cnt_q == PWR_WAKE_CYC) else $error("power wake expired early");
  idle_low_a: assert property (
    !wake_active && !$past(wake_active) |-> !wake_notify_out) else $error("idle high");
  high_len_a: assert property (
    wake_notify_out && prev_q |-> run_q <= 4'h2) else $error("high too long");
  low_len_a: assert property (
    wake_notify_out && !prev_q |-> run_q >= 4'h3) else $error("low too short");
  first_low_a: assert property (
    $rose(wake_active) |-> !wake_notify_out [*3] ##1 wake_notify_out) else $error("bad start");
  pkt_start_a: assert property (
    link_on_pkt_rx && strap_valid && !link_active_ctrl_bit |=> wake_by_pkt) else $error("no start");
  llc_stop_a: assert property (
    (link_power_status_in && link_active_ctrl_bit) [*3] |-> ##[1:2] !wake_by_pkt)
    else $error("no stop");
endmodule // lkn_chk

bind lkn_wake_notify lkn_chk #(.PWR_WAKE_CYC(PWR_WAKE_CYC)) u_chk (.core_clk, .arst_n,
  .mode_strap_five_wake_pin_oe_n, .link_power_status_in, .link_active_ctrl_bit,
  .link_on_pkt_rx, .strap_valid, .wake_notify_out, .wake_active, .wake_by_pkt, .wake_by_pwr,
  .pwr_wake_expired, .power_cycle_evt, .power_class);

// ### sim/lkn_wake_notify_tb_top.sv
// bench for the wake notification block
module lkn_wake_notify_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PWR = 20;
  logic core_clk, arst_n, s5, pkt, brst, pcyc, sleep;
  logic [4:0] s;
  logic [2:0] irq, pc;
  logic [3:0] dly;
  wire pin, oe_n, pst, act, wo, wact, bypwr, sval;
  wire [5:0] smode;
  logic [15:0] q[$];
  logic [31:0] rnd = 32'h7176_a1ef;
  int n_mismatch = 0, comparisons = 0, rises = 0, pwc = 0;
  logic sv_p = 0, act_p = 0, wo_p = 0;
  lkn_wake_notify #(.PWR_WAKE_CYC(PWR)) uut (.core_clk, .arst_n, .mode_strap_zero(s[0]),
    .mode_strap_one(s[1]), .mode_strap_two(s[2]), .mode_strap_three(s[3]),
    .mode_strap_four(s[4]), .mode_strap_five_wake_pin_in(oe_n ? s5 : pin),
    .mode_strap_five_wake_pin_out(pin), .mode_strap_five_wake_pin_oe_n(oe_n),
    .link_power_status_in(pst), .link_active_ctrl_bit(act), .port_event_irq_bit(irq[0]),
    .config_timeout_irq_bit(irq[1]), .cable_power_irq_bit(irq[2]), .link_on_pkt_rx(pkt),
    .bus_reset_evt(brst), .power_cycle_evt(pcyc), .power_class(pc), .strap_mode(smode),
    .strap_valid(sval), .wake_notify_out(wo), .wake_active(wact), .wake_by_pkt(),
    .wake_by_pwr(bypwr), .pwr_wake_expired());
  lkn_llc_model llc (.core_clk, .wake_in(!oe_n && pin), .sleep, .dly, .pwr_status(pst),
    .act_bit(act));
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #200us;
    n_mismatch++;
    end_of_test();
  end
  //////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // lets activation land before polling, so a not-yet-updated flag is not taken as idle
  task automatic settle();
    tick(8);
    for (int k = 0; k < 300 && wact !== 1'h0; k++) tick(1);
    tick(2);
  endtask
  task automatic pkt_brst(input logic [2:0] iv);
    irq <= iv;
    pkt <= 1;
    tick(1);
    pkt <= 0;
    tick(9);
    brst <= 1;
    tick(1);
    brst <= 0;
  endtask
  task automatic pwr(input logic [2:0] c);
    pc <= c;
    pcyc <= 1;
    tick(1);
    pcyc <= 0;
    settle();
  endtask
  //////////////////////////////////////////////////////////////////
  always @(negedge core_clk) begin
    if (sval && !sv_p) chk("strap", {10'h000, smode}, q.pop_front());
    if (act_p && !wact) begin
      chk("wake", 16'(pwc ? pwc : rises), q.pop_front());
      rises = 0;
      pwc = 0;
    end
    if (wo && !wo_p) rises++;
    if (bypwr === 1'h1) pwc++;
    sv_p = sval;
    act_p = wact;
    wo_p = wo;
  end
  initial begin
    arst_n = 0;
    {pkt, brst, pcyc, sleep} = 4'h1;
    {irq, pc, dly} = 10'h000;
    {s5, s} = rnd[5:0];
    q.push_back({10'h000, s5, s});
    tick(4);
    arst_n <= 1;
    tick(8);
    $display("test straps done");
    q.push_back(1);
    pkt_brst(3'h0);
    settle();
    q.push_back(3);
    pkt_brst(3'h1);
    tick(13);
    irq <= 0;
    settle();
    $display("test bus reset done");
    rnd = nx(rnd);
    pwr(3'h5 | {1'h0, rnd[1], 1'h0});
    q.push_back(PWR);
    pwr(3'h4);
    $display("test power cycle done");
    rnd = nx(rnd);
    sleep <= 0;
    dly <= rnd[3:0];
    q.push_back(16'(rnd[3:0] / 4 + 1));
    for (int j = 0; j < 2; j++) begin
      pkt <= 1;
      tick(1);
      pkt <= 0;
      settle();
    end
    for (int i = 0; i < 3; i++) begin
      irq[i] <= 1;
      tick(6);
      q.push_back(16'(dly / 4 + 1));
      sleep <= 1;
      tick(1);
      sleep <= 0;
      settle();
      irq[i] <= 0;
      tick(2);
    end
    $display("test controller done");
    chk("left", 16'(q.size()), 0);
    end_of_test();
  end
endmodule // lkn_wake_notify_tb_top
